// ### pkg/rocf_map.svh
`ifndef ROCF_MAP_SVH
`define ROCF_MAP_SVH

// ==========================================================================
// Option word location and test space
`define ROCF_CFG_ADDR 14'h2007
`define ROCF_TEST_LO 14'h2000
`define ROCF_TEST_HI 14'h3FFF
`define ROCF_ADDR_W 14
`define ROCF_WORD_W 14
`define ROCF_STORE_W 11

// ==========================================================================
// Option word fields
`define ROCF_RESET_PIN_ENABLE_BIT 2
`define ROCF_OSC_MSB 1
`define ROCF_OSC_LSB 0
`define ROCF_WR_MASK 11'h0007
`define ROCF_CFG_UNPROG 11'h07FF
`define ROCF_TOP_ZERO 3'h0
`define ROCF_OSC_HS 2'h3
`define ROCF_OSC_EC 2'h2
`define ROCF_OSC_XT 2'h1
`define ROCF_OSC_LP 2'h0

// ==========================================================================
// Timing
`define ROCF_POWER_UP_DELAY_TIMER_MS 72
`define ROCF_CLK_KHZ 200000
`define ROCF_OST_PERIODS 512
`define ROCF_GLITCH_MIN 4

`endif

// ### pkg/rocf_pkg.sv
package rocf_pkg;

  typedef enum logic [2:0] {
    ST_POR_DELAY,
    ST_OSC_SETTLE,
    ST_RUN,
    ST_SLEEP,
    ST_PIN_RESET
  } rocf_state_type;

  typedef enum logic [1:0] {
    OSC_LOW_POWER,
    OSC_STANDARD,
    OSC_EXT_TEST,
    OSC_HIGH_SPEED
  } rocf_osc_type;

endpackage

// ### logic/rocf_glitch_filter.sv
`timescale 1ns/1ps
`include "rocf_map.svh"

module rocf_glitch_filter
  import rocf_pkg::*;
#(
  parameter int MIN_WIDTH = `ROCF_GLITCH_MIN
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Raw and filtered reset request
  input wire logic raw_i,
  output logic filt_o
);

  localparam int CW = $clog2(MIN_WIDTH + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic filt;
  } rocf_flt_type;

  rocf_flt_type q, d;

  // ==========================================================================
  // Width qualifier: short pulses restart the count and never pass
  always_comb begin
    d = q;
    if (!raw_i) begin
      d.cnt = '0; // R05
      d.filt = 1'b0;
    end else if (q.cnt < CW'(MIN_WIDTH - 1)) begin
      d.cnt = q.cnt + CW'(1); // R17
    end else begin
      d.filt = 1'b1; // R05
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign filt_o = q.filt;

  // ==========================================================================
  glitch_pass_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R05
    $rose(filt_o) |-> $past(raw_i, 1) && $past(q.cnt, 1) == CW'(MIN_WIDTH - 1))
    else $error("Reset passed filter without full width");

endmodule // rocf_glitch_filter

// ### logic/rocf_reset_ctrl.sv
`timescale 1ns/1ps
`include "rocf_map.svh"

// Function
// R01: Tell power-on reset apart from pin reset and report which caused it.
// R02: Unaffected registers are undefined at power-on and kept across other resets.
// R03: Other registers load reset values on power-on, pin reset, pin reset in sleep.
// R04: Wake from sleep keeps all register contents; operation resumes.
// R05: Short glitches on the reset pin are filtered out and cause no reset.
// R06: Power-up delay of 72 ms runs after power-on only.
// R07: Settle timer holds reset until the crystal oscillator is stable.
// R08: Settle delay is 512 oscillator periods, after power-up delay or wake.
// R09: Power-up counter runs on the RC clock; reset held while it counts.
// R10: Sleep ends on pin reset, transmit-on-change, or bus activity.
// R11: Option bits read 0 when programmed and 1 when unprogrammed.
// R12: Option word at 2007h in test space, reachable only in programming mode.
// R13: Oscillator field: 11 high-speed, 10 test clock, 01 standard, 00 low-power.
// R14: Unprogrammed option word gives high-speed crystal mode.
// R15: Bit 2 set enables pin seven as reset input; clear disables it.
// R16: Bits 13-11 read zero; reserved bits 10-3 are left unchanged.
// R17: Filter minimum pulse width is a parameter in clock cycles.
// R18: Pin reset during delays holds reset until pin released and delays done.
module rocf_reset_ctrl
  import rocf_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = `ROCF_POWER_UP_DELAY_TIMER_MS * `ROCF_CLK_KHZ,
  parameter int OST_PERIODS = `ROCF_OST_PERIODS,
  parameter int GLITCH_MIN = `ROCF_GLITCH_MIN
) (
  // Clock (RC-derived) and power-on reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Pins and wake sources
  input wire logic general_pin_seven_n_i,
  input wire logic osc_tick_i,
  input wire logic sleep_req_i,
  input wire logic txc_wake_i,
  input wire logic can_activity_i,
  // Programming access
  input wire logic prog_mode_i,
  input wire logic prog_we_i,
  input wire logic [`ROCF_ADDR_W-1:0] prog_addr_i,
  input wire logic [`ROCF_WORD_W-1:0] prog_wdata_i,
  output logic [`ROCF_WORD_W-1:0] prog_rdata_o,
  // Reset and status
  output logic int_reset_o,
  output logic regs_reset_o,
  output logic cause_por_o,
  output logic cause_pin_o,
  output logic sleep_o,
  output logic [1:0] osc_select_o,
  output logic ext_clock_test_o,
  output logic reset_pin_enable_o
);

  localparam int PW = $clog2(POWER_UP_DELAY_TIMER_CYCLES + 1);
  localparam int OW = $clog2(OST_PERIODS + 1);

  typedef struct packed {
    rocf_state_type state;
    logic [PW-1:0] power_up_delay_timer_cnt;
    logic [OW-1:0] ost_cnt;
    logic por_path;
    logic cause_por;
    logic cause_pin;
    logic [`ROCF_STORE_W-1:0] cfg;
    logic [`ROCF_WORD_W-1:0] rdata;
  } rocf_ctl_type;

  rocf_ctl_type q, d;
  logic pin_filt;
  logic pin_rst;
  logic cfg_hit;
  logic in_test;
  rocf_osc_type osc_mode;

  // ==========================================================================
  // Reset pin path
  rocf_glitch_filter #(
    .MIN_WIDTH(GLITCH_MIN)
  ) u_filter (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .raw_i(~general_pin_seven_n_i),
    .filt_o(pin_filt)
  );

  assign pin_rst = pin_filt && q.cfg[`ROCF_RESET_PIN_ENABLE_BIT]; // R15

  // ==========================================================================
  // Option word decode
  assign cfg_hit = prog_mode_i && (prog_addr_i == `ROCF_CFG_ADDR); // R12
  assign in_test = (prog_addr_i >= `ROCF_TEST_LO) && (prog_addr_i <= `ROCF_TEST_HI);

  always_comb begin
    case (q.cfg[`ROCF_OSC_MSB:`ROCF_OSC_LSB]) // R13
      `ROCF_OSC_HS: osc_mode = OSC_HIGH_SPEED;
      `ROCF_OSC_EC: osc_mode = OSC_EXT_TEST;
      `ROCF_OSC_XT: osc_mode = OSC_STANDARD;
      default: osc_mode = OSC_LOW_POWER;
    endcase
  end

  // ==========================================================================
  // Sequencer
  always_comb begin
    d = q;
    // Only the option bits take writes; reserved bits stay as stored
    if (cfg_hit && prog_we_i) begin
      d.cfg = (q.cfg & ~`ROCF_WR_MASK) | (prog_wdata_i[`ROCF_STORE_W-1:0] & `ROCF_WR_MASK); // R16
    end
    if (cfg_hit && in_test) begin
      d.rdata = {`ROCF_TOP_ZERO, q.cfg}; // R11 R16
    end else begin
      d.rdata = '0; // R12
    end
    case (q.state)
      ST_POR_DELAY: begin
        // Counter keeps running while the pin is held
        if (q.power_up_delay_timer_cnt <= PW'(1)) begin
          d.power_up_delay_timer_cnt = '0;
          d.ost_cnt = '0;
          d.state = ST_OSC_SETTLE; // R08
        end else begin
          d.power_up_delay_timer_cnt = q.power_up_delay_timer_cnt - PW'(1); // R06 R09
        end
      end
      ST_OSC_SETTLE: begin
        if (osc_tick_i && q.ost_cnt < OW'(OST_PERIODS)) begin
          d.ost_cnt = q.ost_cnt + OW'(1); // R08
        end
        if (q.ost_cnt == OW'(OST_PERIODS)) begin
          // Cleared on both exits, else a later wake would reset registers
          d.por_path = 1'b0; // R04
          if (pin_rst) begin
            d.state = ST_PIN_RESET; // R18
            d.cause_pin = 1'b1;
            d.cause_por = 1'b0;
          end else begin
            d.state = ST_RUN; // R07
          end
        end
      end
      ST_RUN: begin
        if (pin_rst) begin
          d.state = ST_PIN_RESET; // R06
          d.cause_pin = 1'b1; // R01
          d.cause_por = 1'b0;
        end else if (sleep_req_i) begin
          d.state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (pin_rst) begin
          d.state = ST_PIN_RESET; // R03 R10
          d.cause_pin = 1'b1;
          d.cause_por = 1'b0;
        end else if (txc_wake_i || can_activity_i) begin
          d.state = ST_OSC_SETTLE; // R04 R10
          d.ost_cnt = '0;
        end
      end
      ST_PIN_RESET: begin
        if (!pin_rst) begin
          d.state = ST_RUN;
        end
      end
      default: d.state = ST_POR_DELAY;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q.state <= ST_POR_DELAY; // R06
      q.power_up_delay_timer_cnt <= PW'(POWER_UP_DELAY_TIMER_CYCLES);
      q.ost_cnt <= '0;
      q.por_path <= 1'b1;
      q.cause_por <= 1'b1; // R01
      q.cause_pin <= 1'b0;
      q.cfg <= `ROCF_CFG_UNPROG; // R14
      q.rdata <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  // Unaffected registers elsewhere simply ignore regs_reset_o
  assign int_reset_o = (q.state != ST_RUN) && (q.state != ST_SLEEP); // R07 R09
  assign regs_reset_o = (q.state == ST_POR_DELAY) || (q.state == ST_PIN_RESET) ||
                        ((q.state == ST_OSC_SETTLE) && q.por_path); // R02 R03
  assign cause_por_o = q.cause_por;
  assign cause_pin_o = q.cause_pin;
  assign sleep_o = (q.state == ST_SLEEP);
  assign osc_select_o = q.cfg[`ROCF_OSC_MSB:`ROCF_OSC_LSB];
  assign ext_clock_test_o = (osc_mode == OSC_EXT_TEST);
  assign reset_pin_enable_o = q.cfg[`ROCF_RESET_PIN_ENABLE_BIT];
  assign prog_rdata_o = q.rdata;

  // ==========================================================================
  // Checks
  sequence s_sleep_wake;
    q.state == ST_SLEEP && !pin_rst && (txc_wake_i || can_activity_i);
  endsequence

  sequence s_settled;
    q.state == ST_OSC_SETTLE && q.ost_cnt == OW'(OST_PERIODS) && !pin_rst;
  endsequence

  por_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R09
    q.state == ST_POR_DELAY |-> int_reset_o && regs_reset_o)
    else $error("Reset not held during power-up delay");

  power_up_delay_timer_end_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R06
    q.state == ST_POR_DELAY && q.power_up_delay_timer_cnt == PW'(1) |=> q.state == ST_OSC_SETTLE && q.ost_cnt == '0)
    else $error("Settle delay did not follow power-up delay");

  ost_release_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R08
    s_settled |=> q.state == ST_RUN && !int_reset_o)
    else $error("Release not after settle count");

  ost_early_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R07
    q.state == ST_OSC_SETTLE && q.ost_cnt < OW'(OST_PERIODS) |=> int_reset_o)
    else $error("Released before oscillator settled");

  pin_no_power_up_delay_timer_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R06
    q.state == ST_RUN && pin_rst |=> q.state == ST_PIN_RESET ##1 q.state != ST_POR_DELAY)
    else $error("Pin reset started power-up delay");

  wake_keep_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R04
    s_sleep_wake |=> q.state == ST_OSC_SETTLE && !regs_reset_o)
    else $error("Wake cleared registers");

  sleep_pin_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R03
    q.state == ST_SLEEP && pin_rst |=> regs_reset_o && cause_pin_o)
    else $error("Pin reset in sleep did not reset registers");

  cause_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R01
    q.state == ST_PIN_RESET |-> cause_pin_o && !cause_por_o)
    else $error("Reset cause wrong");

  pin_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R15
    q.state == ST_RUN && !reset_pin_enable_o |=> q.state != ST_PIN_RESET)
    else $error("Disabled reset pin caused reset");

  hs_default_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R14
    q.cfg == `ROCF_CFG_UNPROG |-> osc_select_o == `ROCF_OSC_HS && !ext_clock_test_o)
    else $error("Unprogrammed word not high-speed");

  prog_only_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R12
    !prog_mode_i |=> prog_rdata_o == '0)
    else $error("Option word visible outside programming");

  top_zero_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R16
    prog_rdata_o[`ROCF_WORD_W-1:`ROCF_STORE_W] == `ROCF_TOP_ZERO)
    else $error("Unimplemented bits not zero");

endmodule // rocf_reset_ctrl

// ### tb/rocf_reset_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "rocf_map.svh"

module rocf_reset_ctrl_tb_top;
  import rocf_pkg::*;
  // Shortened delays keep the run short
  localparam int POWER_UP_DELAY_TIMER = 20;
  localparam int OSCILLATOR_SETTLE_TIMER = 4;
  localparam int GMIN = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic pin_n = 1'b1;
  logic tick = 1'b0;
  logic slp = 1'b0;
  logic txc = 1'b0;
  logic can = 1'b0;
  logic pmode = 1'b0;
  logic pwe = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [13:0] pwdata = 14'h0000;
  logic [13:0] rdata;
  logic int_rst, regs_rst, c_por, c_pin, sleep, ext_test, pin_en, any;
  logic [1:0] osc;
  logic rd_req = 1'b0;
  logic rd_chk = 1'b0;
  logic [13:0] exp_q[$];
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'h2422;
  int n;

  rocf_reset_ctrl #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER), .OST_PERIODS(OSCILLATOR_SETTLE_TIMER), .GLITCH_MIN(GMIN)) u_dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .general_pin_seven_n_i(pin_n), .osc_tick_i(tick),
    .sleep_req_i(slp), .txc_wake_i(txc), .can_activity_i(can), .prog_mode_i(pmode),
    .prog_we_i(pwe), .prog_addr_i(paddr), .prog_wdata_i(pwdata), .prog_rdata_o(rdata),
    .int_reset_o(int_rst), .regs_reset_o(regs_rst), .cause_por_o(c_por),
    .cause_pin_o(c_pin), .sleep_o(sleep), .osc_select_o(osc),
    .ext_clock_test_o(ext_test), .reset_pin_enable_o(pin_en));

  // ==========================================================================
  // Clock, oscillator ticks, timeout
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) tick <= #1 ~tick;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end

  // ==========================================================================
  // Checking helpers
  task automatic chk_word(input string nm, input logic [13:0] e, input logic [13:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic test_done;
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic prog(input logic m, input logic w, input logic [13:0] a,
                      input logic [13:0] d, input logic [13:0] e);
    pmode = m;
    pwe = w;
    paddr = a;
    pwdata = d;
    rd_req = !w;
    if (!w) exp_q.push_back(e);
    step(1);
    pwe = 1'b0;
    rd_req = 1'b0;
    step(1);
  endtask
  task automatic wait_run(output int c);
    c = 0;
    while (int_rst !== 1'b0 && c < 200) begin
      step(1);
      c++;
    end
  endtask

  // ==========================================================================
  // Read monitor: oldest note against the answer
  always @(posedge sys_clk) rd_chk <= rd_req;
  always @(negedge sys_clk) begin
    if (rd_chk) begin
      if (exp_q.size() == 0) chk_flag("read note", 1'b1, 1'b0);
      else chk_word("prog_rdata", exp_q.pop_front(), rdata);
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    step(4);
    chk_flag("int_reset", 1'b1, int_rst);
    chk_flag("regs_reset", 1'b1, regs_rst);
    chk_flag("cause_por", 1'b1, c_por);
    chk_word("osc_select", 14'h0003, {12'h000, osc});
    chk_flag("pin_enable", 1'b1, pin_en);
    rst = 1'b0;
    wait_run(n);
    chk_flag("por wait", 1'b1, n >= POWER_UP_DELAY_TIMER + 6 && n <= POWER_UP_DELAY_TIMER + 12);
    prog(1'b1, 1'b0, `ROCF_CFG_ADDR, 14'h0000, 14'h07FF);
    prog(1'b0, 1'b0, `ROCF_CFG_ADDR, 14'h0000, 14'h0000);
    prog(1'b1, 1'b0, 14'h2006, 14'h0000, 14'h0000);
    for (int k = 0; k < 4; k++) begin
      n = $random(seed);
      prog(1'b1, 1'b1, `ROCF_CFG_ADDR, {n[13:3], 1'b1, k[1:0]}, 14'h0000);
      chk_word("osc_select", 14'(k), {12'h000, osc});
      chk_flag("ext_test", k == 2, ext_test);
      prog(1'b1, 1'b0, `ROCF_CFG_ADDR, 14'h0000, 14'h07FC | 14'(k));
    end
    prog(1'b0, 1'b1, `ROCF_CFG_ADDR, 14'h0000, 14'h0000);
    prog(1'b1, 1'b0, `ROCF_CFG_ADDR, 14'h0000, 14'h07FF);
    // Short pulse must never reach internal reset
    n = 1 + ($unsigned($random(seed)) % (GMIN - 1));
    any = 1'b0;
    pin_n = 1'b0;
    for (int k = 0; k < n + 5; k++) begin
      if (k == n) pin_n = 1'b1;
      step(1);
      any = any | int_rst;
    end
    chk_flag("glitch", 1'b0, any);
    pin_n = 1'b0;
    step(GMIN + 3);
    chk_flag("pin int_reset", 1'b1, int_rst);
    chk_flag("pin regs_reset", 1'b1, regs_rst);
    chk_flag("cause_pin", 1'b1, c_pin);
    chk_flag("cause_por", 1'b0, c_por);
    pin_n = 1'b1;
    wait_run(n);
    chk_flag("pin exit", 1'b1, n <= 3);
    prog(1'b1, 1'b1, `ROCF_CFG_ADDR, 14'h0003, 14'h0000);
    chk_flag("pin_enable", 1'b0, pin_en);
    pin_n = 1'b0;
    step(GMIN + 3);
    chk_flag("pin disabled", 1'b0, int_rst);
    pin_n = 1'b1;
    prog(1'b1, 1'b1, `ROCF_CFG_ADDR, 14'h07FF, 14'h0000);
    // Wake sources: bus activity, change, then pin in sleep
    for (int k = 0; k < 3; k++) begin
      can = 1'b1;
      step(2);
      chk_flag("wake in run", 1'b0, int_rst);
      can = 1'b0;
      slp = 1'b1;
      step(1);
      slp = 1'b0;
      step(1);
      chk_flag("sleep", 1'b1, sleep);
      if (k == 0) can = 1'b1;
      else if (k == 1) txc = 1'b1;
      else pin_n = 1'b0;
      step(k == 2 ? GMIN + 3 : 1);
      can = 1'b0;
      txc = 1'b0;
      pin_n = 1'b1;
      chk_flag("wake int_reset", 1'b1, int_rst);
      chk_flag("wake regs_reset", k == 2, regs_rst);
      wait_run(n);
      chk_flag("wake wait", 1'b1, k == 2 ? n <= 3 : n >= 2 * OSCILLATOR_SETTLE_TIMER - 3 && n <= 2 * OSCILLATOR_SETTLE_TIMER + 3);
    end
    // Pin held through both delays
    rst = 1'b1;
    pin_n = 1'b0;
    step(2);
    rst = 1'b0;
    any = 1'b1;
    for (int k = 0; k < POWER_UP_DELAY_TIMER + 20; k++) begin
      step(1);
      any = any & int_rst;
    end
    chk_flag("held in reset", 1'b1, any);
    pin_n = 1'b1;
    wait_run(n);
    chk_flag("held exit", 1'b1, n <= 4);
    // Wake after a held pin reset must still keep registers
    slp = 1'b1;
    step(1);
    slp = 1'b0;
    can = 1'b1;
    step(1);
    can = 1'b0;
    chk_flag("wake after held", 1'b1, int_rst);
    chk_flag("wake after held regs", 1'b0, regs_rst);
    test_done();
  end
endmodule // rocf_reset_ctrl_tb_top
